// ### rtl/sadm_pkg.sv
// package: address map, targets, pin bundles and timing for the system address decoder
package sadm_pkg;

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam logic [31:0] SADM_ZERO_BASE = 32'h0000_0000;
    localparam logic [31:0] SADM_IMEM_HI_BASE = 32'h1000_0000;
    localparam logic [31:0] SADM_CODE_MASK = 32'hfff0_0000;
    localparam logic [31:0] SADM_DMEM_BASE = 32'h2000_0000;
    localparam logic [31:0] SADM_DMEM_MASK = 32'hfff0_0000;
    localparam logic [31:0] SADM_BRAM_BASE = 32'h6000_0000;
    localparam logic [31:0] SADM_PERIPH_BASE = 32'h4000_0000;
    localparam logic [31:0] SADM_PERIPH_END = 32'h5fff_ffff;
    localparam logic [31:0] SADM_SLOT_MASK = 32'hffff_0000;
    localparam logic [31:0] SADM_EXTDEV_BASE = 32'ha000_0000;
    localparam logic [31:0] SADM_SYSTEM_BASE = 32'he000_0000;
    localparam int unsigned SADM_BRAM_BYTES = 8192;

    // ----------------------------------------------------------------
    // peripheral slots, 64KB each
    // ----------------------------------------------------------------
    localparam int unsigned SADM_NUM_PERIPH = 8;
    localparam logic [SADM_NUM_PERIPH*32-1:0] SADM_PERIPH_BASES = {
        32'h4013_0000,  // 7: base board flash controller
        32'h4012_0000,  // 6: gpio block c
        32'h4011_0000,  // 5: gpio block b
        32'h4010_0000,  // 4: serial port
        32'h4003_0000,  // 3: adaptor single spi
        32'h4002_0000,  // 2: adaptor flash, normal mode
        32'h4001_0000,  // 1: gpio block a, holds the flash select
        32'h4000_0000   // 0: adaptor flash, execute in place
    };

    // ----------------------------------------------------------------
    // interrupt line numbers
    // ----------------------------------------------------------------
    localparam int unsigned SADM_IRQ_WIDTH = 32;
    localparam int unsigned SADM_NUM_IRQ_SRC = 7;
    localparam int unsigned SADM_IRQ_PRESENT_LINE = 31;

    // ----------------------------------------------------------------
    // reset and strap timing
    // ----------------------------------------------------------------
    localparam int unsigned SADM_CLK_MHZ = 125;
    localparam int unsigned SADM_CPU_HOLD_NS = 64;
    localparam int unsigned SADM_CPU_HOLD_CYC =
        (SADM_CPU_HOLD_NS * SADM_CLK_MHZ + 999) / 1000;
    localparam int unsigned SADM_FLASH_IO = 4;

    typedef enum logic [2:0] {
        SADM_TGT_NONE = 3'b000,
        SADM_TGT_IMEM = 3'b001,
        SADM_TGT_DMEM = 3'b010,
        SADM_TGT_XIP_CODE = 3'b011,
        SADM_TGT_BRAM = 3'b100,
        SADM_TGT_PERIPH = 3'b101,
        SADM_TGT_SYSTEM = 3'b110
    } sadm_tgt_t;

    typedef enum logic [1:0] {
        SADM_ST_RESET = 2'b00,
        SADM_ST_STRAP = 2'b01,
        SADM_ST_HOLD = 2'b10,
        SADM_ST_RUN = 2'b11
    } sadm_state_t;

    typedef struct packed {
        logic valid;
        logic fetch;
        logic write;
        logic [31:0] addr;
    } sadm_req_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic [SADM_FLASH_IO-1:0] io_out;
        logic [SADM_FLASH_IO-1:0] io_oe;
    } sadm_flash_pins_t;

endpackage

// ### rtl/sadm_flash_mux.sv
// module: registered two-to-one owner switch for the adaptor flash pins
`timescale 1ns/1ps
`default_nettype none
module sadm_flash_mux
    import sadm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic sel_normal_in,
    input wire sadm_flash_pins_t xip_pins_in,
    input wire sadm_flash_pins_t nrm_pins_in,
    input wire logic [SADM_FLASH_IO-1:0] pad_io_in,
    output sadm_flash_pins_t pad_pins_out,
    output logic [SADM_FLASH_IO-1:0] xip_io_out,
    output logic [SADM_FLASH_IO-1:0] nrm_io_out
);
    // ----------------------------------------------------------------
    // pin ownership
    // ----------------------------------------------------------------
    // idle pins: chip select high, clock low, no drive
    localparam sadm_flash_pins_t IDLE_PINS = '{sclk: 1'b0, cs_n: 1'b1,
        io_out: '0, io_oe: '0};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pad_pins_out <= IDLE_PINS;
        end else if (ce_in) begin
            pad_pins_out <= sel_normal_in ? nrm_pins_in : xip_pins_in;
        end
    end

    // the deselected controller sees a quiet bus, so it cannot act on
    // traffic that belongs to the other one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            xip_io_out <= '0;
            nrm_io_out <= '0;
        end else if (ce_in) begin
            xip_io_out <= sel_normal_in ? '0 : pad_io_in;
            nrm_io_out <= sel_normal_in ? pad_io_in : '0;
        end
    end
endmodule // sadm_flash_mux
`default_nettype wire

// ### rtl/sadm_top.sv
// module: system address decoder, boot alias, flash owner switch and interrupt map
`timescale 1ns/1ps
`default_nettype none
module sadm_top
    import sadm_pkg::*;
#(
    parameter int unsigned BRAM_BYTES = SADM_BRAM_BYTES,
    parameter int unsigned CPU_HOLD_CYC = SADM_CPU_HOLD_CYC
)(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // strap from the adaptor connector, low when fitted
    input wire logic adaptor_present_n_in,
    // processor bus request
    input wire sadm_req_t req_in,
    // decode answer
    output logic resp_valid_out,
    output sadm_tgt_t resp_target_out,
    output logic [SADM_NUM_PERIPH-1:0] resp_periph_sel_out,
    output logic resp_err_out,
    output logic resp_nx_out,
    output logic [31:0] err_addr_out,
    // boot control
    output logic cpu_rst_n_out,
    output logic adaptor_fitted_out,
    // flash owner switch, high selects the normal-mode controller
    input wire logic flash_sel_normal_in,
    input wire sadm_flash_pins_t xip_pins_in,
    input wire sadm_flash_pins_t nrm_pins_in,
    input wire logic [SADM_FLASH_IO-1:0] flash_io_in,
    output sadm_flash_pins_t flash_pins_out,
    output logic [SADM_FLASH_IO-1:0] xip_io_out,
    output logic [SADM_FLASH_IO-1:0] nrm_io_out,
    // interrupt sources, in line order 0..6
    input wire logic [SADM_NUM_IRQ_SRC-1:0] irq_src_in,
    output logic [SADM_IRQ_WIDTH-1:0] irq_out
);
    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    localparam int unsigned HOLD_W = (CPU_HOLD_CYC < 2) ? 1 : $clog2(CPU_HOLD_CYC + 1);

    generate
        if (BRAM_BYTES < 4 || (BRAM_BYTES & (BRAM_BYTES - 1)) != 0) begin : g_bad_bram
            $error("block ram size must be a power of two of at least four bytes");
        end
        if (CPU_HOLD_CYC < 1) begin : g_bad_hold
            $error("processor reset hold must be at least one cycle");
        end
    endgenerate

    localparam logic [31:0] BRAM_MASK = ~(32'(BRAM_BYTES) - 32'h0000_0001);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // strap capture and processor reset hold
    // ----------------------------------------------------------------
    sadm_state_t state_r;
    sadm_state_t state_nxt;
    logic [HOLD_W-1:0] hold_cnt_r;
    logic fitted_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SADM_ST_RESET: state_nxt = SADM_ST_STRAP;
            SADM_ST_STRAP: state_nxt = SADM_ST_HOLD;
            SADM_ST_HOLD: begin
                if (hold_cnt_r == HOLD_W'(CPU_HOLD_CYC - 1)) begin
                    state_nxt = SADM_ST_RUN;
                end
            end
            SADM_ST_RUN: state_nxt = SADM_ST_RUN;
            default: state_nxt = SADM_ST_RESET;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r <= SADM_ST_RESET;
        end else if (clk_en_in) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            hold_cnt_r <= '0;
        end else if (clk_en_in) begin
            if (state_r == SADM_ST_HOLD) begin
                hold_cnt_r <= hold_cnt_r + HOLD_W'(1);
            end else begin
                hold_cnt_r <= '0;
            end
        end
    end

    // the strap is frozen once caught; a board plugged in later takes
    // effect only after the next reset, so the boot alias never moves
    // under a running processor
    always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            fitted_r <= 1'b0;
        end else if (clk_en_in && state_r == SADM_ST_STRAP) begin
            fitted_r <= ~adaptor_present_n_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            cpu_rst_n_out <= 1'b0;
            adaptor_fitted_out <= 1'b0;
        end else if (clk_en_in) begin
            cpu_rst_n_out <= (state_nxt == SADM_ST_RUN);
            adaptor_fitted_out <= fitted_r;
        end
    end

    // ----------------------------------------------------------------
    // peripheral slot match
    // ----------------------------------------------------------------
    logic [SADM_NUM_PERIPH-1:0] slot_hit;

    genvar gi;
    generate
        for (gi = 0; gi < SADM_NUM_PERIPH; gi++) begin : g_slot
            assign slot_hit[gi] = (req_in.addr & SADM_SLOT_MASK)
                == SADM_PERIPH_BASES[gi*32 +: 32];
        end
    endgenerate

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    sadm_tgt_t tgt_nxt;
    logic err_nxt;
    logic nx_nxt;
    logic in_periph;
    logic in_zero;
    logic in_imem_hi;

    assign in_periph = (req_in.addr >= SADM_PERIPH_BASE) && (req_in.addr <= SADM_PERIPH_END);
    assign in_zero = (req_in.addr & SADM_CODE_MASK) == SADM_ZERO_BASE;
    assign in_imem_hi = (req_in.addr & SADM_CODE_MASK) == SADM_IMEM_HI_BASE;

    always_comb begin
        tgt_nxt = SADM_TGT_NONE;
        err_nxt = 1'b0;
        nx_nxt = 1'b0;
        if (in_zero) begin
            // the boot alias follows the caught strap
            tgt_nxt = fitted_r ? SADM_TGT_XIP_CODE : SADM_TGT_IMEM;
        end else if (in_imem_hi) begin
            tgt_nxt = SADM_TGT_IMEM;
        end else if ((req_in.addr & SADM_DMEM_MASK) == SADM_DMEM_BASE) begin
            if (req_in.fetch) begin
                nx_nxt = 1'b1;
                err_nxt = 1'b1;
            end else begin
                tgt_nxt = SADM_TGT_DMEM;
            end
        end else if ((req_in.addr & BRAM_MASK) == SADM_BRAM_BASE) begin
            tgt_nxt = SADM_TGT_BRAM;
        end else if (in_periph && (|slot_hit)) begin
            tgt_nxt = SADM_TGT_PERIPH;
        end else if (req_in.addr >= SADM_SYSTEM_BASE) begin
            // private processor space, resolved inside the core
            tgt_nxt = SADM_TGT_SYSTEM;
        end else begin
            // external gaps, unused peripheral slots, unused ram and
            // the whole external device space end here
            err_nxt = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // decode answer, one cycle after the request
    // ----------------------------------------------------------------
    logic bus_live;

    assign bus_live = req_in.valid && (state_r == SADM_ST_RUN);

    always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            resp_valid_out <= 1'b0;
            resp_target_out <= SADM_TGT_NONE;
            resp_periph_sel_out <= '0;
            resp_err_out <= 1'b0;
            resp_nx_out <= 1'b0;
        end else if (clk_en_in) begin
            resp_valid_out <= bus_live;
            if (bus_live) begin
                resp_target_out <= tgt_nxt;
                resp_periph_sel_out <= (tgt_nxt == SADM_TGT_PERIPH) ? slot_hit : '0;
                resp_err_out <= err_nxt;
                resp_nx_out <= nx_nxt;
            end else begin
                resp_target_out <= SADM_TGT_NONE;
                resp_periph_sel_out <= '0;
                resp_err_out <= 1'b0;
                resp_nx_out <= 1'b0;
            end
        end
    end

    // last refused address stays until the next refusal, for fault handlers
    always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            err_addr_out <= '0;
        end else if (clk_en_in && bus_live && err_nxt) begin
            err_addr_out <= req_in.addr;
        end
    end

    // ----------------------------------------------------------------
    // flash owner switch
    // ----------------------------------------------------------------
    // no interlock here: flipping to the normal controller while code
    // runs from flash starves the fetch path, and software owns that
    sadm_flash_mux u_flash_mux (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_sync_r),
        .ce_in(clk_en_in),
        .sel_normal_in(flash_sel_normal_in),
        .xip_pins_in(xip_pins_in),
        .nrm_pins_in(nrm_pins_in),
        .pad_io_in(flash_io_in),
        .pad_pins_out(flash_pins_out),
        .xip_io_out(xip_io_out),
        .nrm_io_out(nrm_io_out)
    );

    // ----------------------------------------------------------------
    // interrupt map
    // ----------------------------------------------------------------
    logic [SADM_IRQ_WIDTH-1:0] irq_nxt;

    always_comb begin
        irq_nxt = '0;
        irq_nxt[SADM_NUM_IRQ_SRC-1:0] = irq_src_in;
        // a level, read by software as board presence
        irq_nxt[SADM_IRQ_PRESENT_LINE] = adaptor_present_n_in;
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            irq_out <= '0;
        end else if (clk_en_in) begin
            irq_out <= irq_nxt;
        end
    end
endmodule // sadm_top
`default_nettype wire

// ### dv/sadm_top_props.sv
// checker: decode, boot alias, flash owner switch and interrupt line properties
`timescale 1ns/1ps
`default_nettype none
module sadm_top_props
    import sadm_pkg::*;
#(
    parameter int unsigned BRAM_BYTES = SADM_BRAM_BYTES,
    parameter int unsigned CPU_HOLD_CYC = SADM_CPU_HOLD_CYC
)(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic adaptor_present_n_in,
    input wire sadm_req_t req_in,
    input wire logic resp_valid_out,
    input wire sadm_tgt_t resp_target_out,
    input wire logic [SADM_NUM_PERIPH-1:0] resp_periph_sel_out,
    input wire logic resp_err_out,
    input wire logic resp_nx_out,
    input wire logic cpu_rst_n_out,
    input wire logic adaptor_fitted_out,
    input wire logic flash_sel_normal_in,
    input wire sadm_flash_pins_t xip_pins_in,
    input wire sadm_flash_pins_t nrm_pins_in,
    input wire logic [SADM_FLASH_IO-1:0] flash_io_in,
    input wire sadm_flash_pins_t flash_pins_out,
    input wire logic [SADM_FLASH_IO-1:0] xip_io_out,
    input wire logic [SADM_FLASH_IO-1:0] nrm_io_out,
    input wire logic [SADM_NUM_IRQ_SRC-1:0] irq_src_in,
    input wire logic [SADM_IRQ_WIDTH-1:0] irq_out
);
    // ----------------------------------------------------------------
    // properties, all on the system clock
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic take;
    // only a running processor with the clock enabled gets an answer
    assign take = cpu_rst_n_out && clk_en_in && req_in.valid;

    resp_no_hang_a: assert property (take |=> resp_valid_out)
        else $error("request got no answer");
    bram_route_a: assert property (take && req_in.addr >= SADM_BRAM_BASE
        && req_in.addr < SADM_BRAM_BASE + 32'(BRAM_BYTES)
        |=> resp_target_out == SADM_TGT_BRAM && !resp_err_out)
        else $error("block ram window misrouted");
    periph_only_a: assert property (resp_valid_out && resp_target_out == SADM_TGT_PERIPH
        |-> $past(req_in.addr[31:29]) == 3'b010 && $onehot(resp_periph_sel_out))
        else $error("peripheral hit outside peripheral region");
    ext_unused_a: assert property (take && req_in.addr[31:29] inside {3'b101, 3'b110}
        |=> resp_err_out && resp_target_out == SADM_TGT_NONE)
        else $error("unused external space answered");
    dmem_nx_a: assert property (take && req_in.fetch && req_in.addr[31:20] == 12'h200
        |=> resp_err_out && resp_nx_out && resp_target_out == SADM_TGT_NONE)
        else $error("fetch from data memory served");
    dmem_base_a: assert property (take && !req_in.fetch && req_in.addr[31:20] == 12'h200
        |=> resp_target_out == SADM_TGT_DMEM && !resp_nx_out)
        else $error("data memory not at its base");
    imem_upper_a: assert property (take && req_in.addr[31:20] == 12'h100
        |=> resp_target_out == SADM_TGT_IMEM)
        else $error("upper code alias lost");
    zero_alias_a: assert property (take && req_in.addr[31:20] == 12'h000
        |=> resp_target_out == (adaptor_fitted_out ? SADM_TGT_XIP_CODE : SADM_TGT_IMEM))
        else $error("address zero alias wrong");
    strap_frozen_a: assert property (cpu_rst_n_out |-> $stable(adaptor_fitted_out))
        else $error("strap changed while running");
    irq_map_a: assert property (cpu_rst_n_out && clk_en_in
        |=> irq_out == {$past(adaptor_present_n_in), 24'h0, $past(irq_src_in)})
        else $error("interrupt lines misplaced");
    flash_nrm_a: assert property (cpu_rst_n_out && clk_en_in && flash_sel_normal_in
        |=> flash_pins_out == $past(nrm_pins_in) && nrm_io_out == $past(flash_io_in)
        && xip_io_out == '0)
        else $error("normal controller not owning flash");
    flash_xip_a: assert property (cpu_rst_n_out && clk_en_in && !flash_sel_normal_in
        |=> flash_pins_out == $past(xip_pins_in) && xip_io_out == $past(flash_io_in)
        && nrm_io_out == '0)
        else $error("xip controller not owning flash");
endmodule // sadm_top_props

bind sadm_top sadm_top_props #(.BRAM_BYTES(BRAM_BYTES), .CPU_HOLD_CYC(CPU_HOLD_CYC)) u_props (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .adaptor_present_n_in(adaptor_present_n_in), .req_in(req_in),
    .resp_valid_out(resp_valid_out), .resp_target_out(resp_target_out),
    .resp_periph_sel_out(resp_periph_sel_out), .resp_err_out(resp_err_out),
    .resp_nx_out(resp_nx_out), .cpu_rst_n_out(cpu_rst_n_out),
    .adaptor_fitted_out(adaptor_fitted_out), .flash_sel_normal_in(flash_sel_normal_in),
    .xip_pins_in(xip_pins_in), .nrm_pins_in(nrm_pins_in), .flash_io_in(flash_io_in),
    .flash_pins_out(flash_pins_out), .xip_io_out(xip_io_out), .nrm_io_out(nrm_io_out),
    .irq_src_in(irq_src_in), .irq_out(irq_out)
);
`default_nettype wire

// ### dv/sadm_cpu_model.sv
// partner: processor bus master issuing one fetch or data access per call
`timescale 1ns/1ps
`default_nettype none
module sadm_cpu_model
    import sadm_pkg::*;
(
    input wire logic clk_in,
    input wire logic cpu_rst_n_in,
    output var sadm_req_t req_out
);
    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    initial req_out = '0;
    // the request stays up past the taking edge so calls run back to back
    task automatic issue(input logic fetch, input logic write, input logic [31:0] addr);
        while (cpu_rst_n_in !== 1'b1) @(posedge clk_in);
        req_out <= '{valid: 1'b1, fetch: fetch, write: write, addr: addr};
        @(posedge clk_in);
    endtask
    // a released bus shows a changed address, never the last one
    task automatic idle();
        req_out <= '{valid: 1'b0, fetch: 1'b0, write: 1'b0, addr: ~req_out.addr};
        @(posedge clk_in);
    endtask
endmodule // sadm_cpu_model
`default_nettype wire

// ### dv/tb_system_address_decode_irq_map.sv
// testbench: decode map, boot alias, flash owner switch and interrupt lines
`timescale 1ns/1ps
`default_nettype none
module tb_system_address_decode_irq_map;
    import sadm_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and design
    // ----------------------------------------------------------------
    localparam int unsigned HOLD = 2;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic clk_en = 1'b1;
    logic present_n = 1'b1;
    logic sel_nrm = 1'b0;
    sadm_flash_pins_t xip_p = '0;
    sadm_flash_pins_t nrm_p = '0;
    sadm_flash_pins_t pins;
    logic [3:0] pad_io = 4'h0;
    logic [3:0] xio, nio;
    logic [6:0] irq_src = 7'h00;
    sadm_req_t req;
    sadm_tgt_t tgt;
    logic rv, err, nx, cpu_rst_n, fitted;
    logic [7:0] psel;
    logic [31:0] err_addr, irq;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    always #4 ref_clk_in = ~ref_clk_in;

    sadm_cpu_model cpu (.clk_in(ref_clk_in), .cpu_rst_n_in(cpu_rst_n), .req_out(req));
    sadm_top #(.CPU_HOLD_CYC(HOLD)) DUT (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
        .adaptor_present_n_in(present_n), .req_in(req), .resp_valid_out(rv),
        .resp_target_out(tgt), .resp_periph_sel_out(psel), .resp_err_out(err),
        .resp_nx_out(nx), .err_addr_out(err_addr), .cpu_rst_n_out(cpu_rst_n),
        .adaptor_fitted_out(fitted), .flash_sel_normal_in(sel_nrm), .xip_pins_in(xip_p),
        .nrm_pins_in(nrm_p), .flash_io_in(pad_io), .flash_pins_out(pins),
        .xip_io_out(xio), .nrm_io_out(nio), .irq_src_in(irq_src), .irq_out(irq)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic f, input logic w, input logic [31:0] a, input sadm_tgt_t t,
                       input logic e, input logic [7:0] s);
        cpu.issue(f, w, a);
        #1;
        cmp("answer", 32'h1, 32'(rv));
        cmp("target", 32'(t), 32'(tgt));
        cmp("error", 32'(e), 32'(err));
        cmp("slot", 32'(s), 32'(psel));
    endtask
    task automatic do_reset(input logic strap_n);
        int n;
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        present_n <= strap_n;
        repeat (16) @(posedge ref_clk_in);
        #1;
        cmp("select in reset", 32'h1, 32'(pins.cs_n));
        cmp("cpu reset", 32'h0, 32'(cpu_rst_n));
        rst_n_in <= 1'b1;
        n = 0;
        while (cpu_rst_n !== 1'b1 && n < 40) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        cmp("cpu run", 32'h1, 32'(cpu_rst_n));
        cmp("strap", 32'(!strap_n), 32'(fitted));
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_map();
        do_reset(1'b1);
        acc(1'b1, 1'b0, 32'h0000_0000, SADM_TGT_IMEM, 1'b0, 8'h00);
        acc(1'b1, 1'b0, 32'h1000_0000, SADM_TGT_IMEM, 1'b0, 8'h00);
        acc(1'b1, 1'b0, 32'h6000_0000, SADM_TGT_BRAM, 1'b0, 8'h00);
        acc(1'b0, 1'b1, 32'h6000_1ffc, SADM_TGT_BRAM, 1'b0, 8'h00);
        acc(1'b0, 1'b0, 32'h6000_2000, SADM_TGT_NONE, 1'b1, 8'h00);
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, 1'b0, SADM_PERIPH_BASES[i*32+:32] + 32'h10, SADM_TGT_PERIPH, 1'b0,
                8'(1 << i));
        end
        acc(1'b0, 1'b0, 32'h4004_0000, SADM_TGT_NONE, 1'b1, 8'h00);
        acc(1'b0, 1'b0, 32'h4014_0000, SADM_TGT_NONE, 1'b1, 8'h00);
        acc(1'b0, 1'b0, 32'h2000_0000, SADM_TGT_DMEM, 1'b0, 8'h00);
        acc(1'b1, 1'b0, 32'h200f_fffc, SADM_TGT_NONE, 1'b1, 8'h00);
        cmp("never execute", 32'h1, 32'(nx));
        cmp("refused address", 32'h200f_fffc, err_addr);
        acc(1'b0, 1'b0, 32'ha000_0000, SADM_TGT_NONE, 1'b1, 8'h00);
        acc(1'b0, 1'b1, 32'hdfff_fffc, SADM_TGT_NONE, 1'b1, 8'h00);
        acc(1'b0, 1'b0, 32'h0010_0000, SADM_TGT_NONE, 1'b1, 8'h00);
        acc(1'b0, 1'b0, 32'he000_e000, SADM_TGT_SYSTEM, 1'b0, 8'h00);
        cpu.idle();
        clk_en <= 1'b0;
        cpu.issue(1'b0, 1'b0, 32'h6000_0010);
        #1;
        cmp("frozen answer", 32'h0, 32'(rv));
        clk_en <= 1'b1;
        @(posedge ref_clk_in);
        #1;
        cmp("resumed answer", 32'h1, 32'(rv));
        cpu.idle();
        $display("test address map done");
    endtask
    task automatic t_fitted();
        sel_nrm <= 1'b0;
        do_reset(1'b0);
        acc(1'b1, 1'b0, 32'h0000_0000, SADM_TGT_XIP_CODE, 1'b0, 8'h00);
        acc(1'b1, 1'b0, 32'h1000_0000, SADM_TGT_IMEM, 1'b0, 8'h00);
        acc(1'b0, 1'b0, 32'h2000_0004, SADM_TGT_DMEM, 1'b0, 8'h00);
        present_n <= 1'b1;
        cpu.idle();
        acc(1'b1, 1'b0, 32'h0000_0040, SADM_TGT_XIP_CODE, 1'b0, 8'h00);
        cmp("present line", 32'h1, 32'(irq[31]));
        present_n <= 1'b0;
        cpu.idle();
        $display("test boot with adaptor done");
    endtask
    task automatic t_irq();
        for (int i = 0; i < 7; i++) begin
            irq_src <= 7'(1 << i);
            @(posedge ref_clk_in);
            #1;
            cmp("irq lines", {present_n, 24'h0, 7'(1 << i)}, irq);
        end
        $display("test interrupt lines done");
    endtask
    task automatic t_flash();
        xip_p <= 10'h2a5;
        nrm_p <= 10'h15a;
        pad_io <= 4'h9;
        @(posedge ref_clk_in);
        #1;
        cmp("pins xip", 32'h2a5, 32'(pins));
        cmp("io xip", 32'h9, 32'(xio));
        cmp("io normal idle", 32'h0, 32'(nio));
        sel_nrm <= 1'b1;
        pad_io <= 4'h6;
        @(posedge ref_clk_in);
        #1;
        cmp("pins normal", 32'h15a, 32'(pins));
        cmp("io normal", 32'h6, 32'(nio));
        cmp("io xip idle", 32'h0, 32'(xio));
        $display("test flash owner done");
    endtask

    // a hang ends the run through the same verdict
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            $display("BAD run length expected under 2000 seen 2000");
            give_verdict();
        end
    end
    initial begin
        t_map();
        t_fitted();
        t_irq();
        t_flash();
        give_verdict();
    end
endmodule // tb_system_address_decode_irq_map
`default_nettype wire
